// file: rtl/accel_output_path.sv
// Summary of operation
// - Low byte holds sample bits 5:0 high
// - Y/Z high bytes hold bits 13:6
// - FIFO setup: mode 7:6, watermark 5:0
// - Above watermark flag, keep accepting samples
// - Load FIFO at wake or sleep rate
// - FIFO read returns oldest, count decrements
// - Partial burst: next read starts X
// - Unread Y/Z of burst are discarded
// - Trigger mode circular before trigger event
// - After trigger, fill then drop new
// - Data config bit 4 selects filtered output
// - Range code selects 2, 4, 8 g
// - Cutoff bit 5 bypasses tap high-pass
// - Cutoff bit 4 enables tap low-pass
// - Cutoff field sets high-pass corner
// - Hybrid mode halves rate and corner
// - Fourteen-bit two's complement, left justified
// - FIFO on: X high is head, rest zero
// - Fast read skips low bytes on increment
`timescale 1ns/1ps
module accel_output_path #(
	parameter int BASE_DIV_CYC = accel_pkg::BASE_DIV
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [accel_pkg::SAMPLE_W-1:0] x_sample_bits,
	input wire logic [accel_pkg::SAMPLE_W-1:0] y_sample_bits,
	input wire logic [accel_pkg::SAMPLE_W-1:0] z_sample_bits,
	input wire logic [2:0] wake_rate_field,
	input wire logic [2:0] sleep_rate_field,
	input wire logic sleep_active,
	input wire logic hybrid_mode,
	input wire logic fast_read,
	input wire logic [1:0] power_mode,
	input wire logic trig_event,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic burst_end,
	output logic [7:0] reg_rdata,
	output logic [7:0] reg_next_addr,
	output logic fifo_watermark_flag,
	output logic fifo_overflow,
	output logic [1:0] range_select,
	output logic tap_hpf_bypass,
	output logic tap_lpf_en
);
	import accel_pkg::*;

	// Whole state of the block
	typedef struct packed {
		logic [FIFO_DEPTH-1:0][FIFO_W-1:0] mem; // Sample store
		logic [PTR_W-1:0] wr_ptr; // Next slot to fill
		logic [PTR_W-1:0] rd_ptr; // Oldest sample
		logic [CNT_W-1:0] cnt; // Stored samples
		logic [2:0] pos; // Byte position within head
		logic trig_seen; // Trigger event taken
		logic ovf; // Sticky overflow
		logic wm; // Above watermark
		logic [31:0] div_cnt; // Rate divider
		logic tick; // Sample strobe
		logic ld_pend; // Filter output ready
		logic [SAMPLE_W-1:0] x_r; // Latest samples
		logic [SAMPLE_W-1:0] y_r;
		logic [SAMPLE_W-1:0] z_r;
		logic [7:0] fset; // FIFO setup
		logic [7:0] dcfg; // Range and output filter
		logic [7:0] hcut; // Cutoff and tap filters
		logic [7:0] rdata; // Read answer
		logic [7:0] next_addr; // Auto-increment address
	} path_s;

	path_s st_r;
	path_s st_nxt;
	logic [1:0] mode; // Current FIFO mode
	logic fifo_on; // FIFO drives the data window
	logic [2:0] last; // Last byte position of a sample
	logic [3:0] rate; // Effective rate shift
	logic [31:0] period; // Cycles per sample
	logic [3:0] hpf_shift; // Filter corner shift
	logic [2:0][SAMPLE_W-1:0] raw; // Front-end sample
	logic [2:0][SAMPLE_W-1:0] filt; // Filtered sample
	logic [FIFO_W-1:0] smp; // Sample to store
	logic [FIFO_W-1:0] head; // Oldest stored sample
	logic full; // No free slot
	logic circ; // Overwrite when full
	logic pop; // Remove head sample

	// Byte of the head sample at a read position
	function automatic logic [7:0] fifo_byte(input logic [FIFO_W-1:0] w,
		input logic [2:0] p, input logic fast);
		logic [1:0] ax;
		logic lo;
		logic [SAMPLE_W-1:0] s;
		ax = fast ? p[1:0] : p[2:1];
		lo = fast ? 1'b0 : p[0];
		case (ax)
			2'h0: s = w[FIFO_W-1 -: SAMPLE_W];
			2'h1: s = w[2*SAMPLE_W-1 -: SAMPLE_W];
			default: s = w[SAMPLE_W-1:0];
		endcase
		return lo ? lo_byte(s) : hi_byte(s);
	endfunction

	assign mode = st_r.fset[FMODE_HI:FMODE_LO];
	assign fifo_on = mode != FMODE_OFF;
	assign last = fast_read ? LAST_FAST : LAST_FULL;
	assign raw = {x_sample_bits, y_sample_bits, z_sample_bits};

	// System rate: sleep rate while asleep, halved in hybrid
	assign rate = rate_shift(sleep_active ? sleep_rate_field
		: wake_rate_field) + {3'h0, hybrid_mode};
	assign period = 32'(BASE_DIV_CYC) << rate;

	// Longer average gives lower corner; code 0 is highest
	assign hpf_shift = HPF_BASE_SHIFT
		+ {2'h0, st_r.hcut[CUT_HI:0]}
		+ {3'h0, power_mode == PWR_LOW_POWER};

	// Output filter runs once per sample strobe
	accel_hpf u_hpf (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.en(st_r.tick),
		.shift(hpf_shift),
		.raw(raw),
		.filt(filt)
	);

	// Next state
	always_comb begin
		st_nxt = st_r;
		pop = 1'b0;
		head = st_r.mem[st_r.rd_ptr];
		smp = st_r.dcfg[HPF_OUT_BIT] ? filt : raw;
		full = 1'b0;
		circ = 1'b0;
		// Rate divider
		st_nxt.tick = 1'b0;
		if (st_r.div_cnt >= period - 32'h1) begin
			st_nxt.div_cnt = 32'h0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.div_cnt = st_r.div_cnt + 32'h1;
		end
		st_nxt.ld_pend = st_r.tick;
		// Register reads
		if (reg_rd) begin
			st_nxt.rdata = 8'h00;
			st_nxt.next_addr = reg_addr + 8'h01;
			// Fast read steps over the low bytes
			if (fast_read && (reg_addr == ADDR_XH ||
				reg_addr == ADDR_YH || reg_addr == ADDR_ZH)) begin
				st_nxt.next_addr = reg_addr + 8'h02;
			end
			case (reg_addr)
				ADDR_STATUS: begin
					// Status read shows and clears overflow
					st_nxt.rdata = {st_r.ovf, st_r.wm, st_r.cnt};
					st_nxt.ovf = 1'b0;
				end
				ADDR_XH: begin
					if (fifo_on) begin
						// Head stream stays on this address
						st_nxt.next_addr = ADDR_XH;
						if (st_r.cnt != '0) begin
							st_nxt.rdata = fifo_byte(head,
								st_r.pos, fast_read);
							if (st_r.pos >= last) begin
								pop = 1'b1;
							end else begin
								st_nxt.pos = st_r.pos + 3'h1;
							end
						end
					end else begin
						st_nxt.rdata = hi_byte(st_r.x_r);
					end
				end
				// Low and Y/Z bytes read zero while FIFO is on
				ADDR_XL: begin
					if (!fifo_on) begin
						st_nxt.rdata = lo_byte(st_r.x_r);
					end
				end
				ADDR_YH: begin
					if (!fifo_on) begin
						st_nxt.rdata = hi_byte(st_r.y_r);
					end
				end
				ADDR_YL: begin
					if (!fifo_on) begin
						st_nxt.rdata = lo_byte(st_r.y_r);
					end
				end
				ADDR_ZH: begin
					if (!fifo_on) begin
						st_nxt.rdata = hi_byte(st_r.z_r);
					end
				end
				ADDR_ZL: begin
					if (!fifo_on) begin
						st_nxt.rdata = lo_byte(st_r.z_r);
					end
				end
				ADDR_FSETUP: begin
					st_nxt.rdata = st_r.fset;
				end
				ADDR_DCFG: begin
					st_nxt.rdata = st_r.dcfg;
				end
				ADDR_HCUT: begin
					st_nxt.rdata = st_r.hcut;
				end
				default: begin
					st_nxt.rdata = 8'h00;
				end
			endcase
		end else if (burst_end && st_r.pos != 3'h0) begin
			// Burst stopped inside a sample: drop its remainder
			pop = 1'b1;
		end
		// Removing the head realigns the next read to X
		if (pop) begin
			st_nxt.rd_ptr = st_r.rd_ptr + 5'h01;
			st_nxt.cnt = st_r.cnt - 6'h01;
			st_nxt.pos = 3'h0;
		end
		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				ADDR_FSETUP: begin
					// Mode changes assume a pass through off
					st_nxt.fset = reg_wdata;
					if (reg_wdata[FMODE_HI:FMODE_LO] != mode) begin
						st_nxt.trig_seen = 1'b0;
					end
					// Turning the FIFO off empties it
					if (reg_wdata[FMODE_HI:FMODE_LO] == FMODE_OFF) begin
						st_nxt.wr_ptr = '0;
						st_nxt.rd_ptr = '0;
						st_nxt.cnt = '0;
						st_nxt.pos = 3'h0;
					end
				end
				ADDR_DCFG: begin
					st_nxt.dcfg = reg_wdata;
				end
				ADDR_HCUT: begin
					st_nxt.hcut = reg_wdata;
				end
				default: begin
				end
			endcase
		end
		// Trigger event only counts in trigger mode
		if (trig_event && mode == FMODE_TRIG) begin
			st_nxt.trig_seen = 1'b1;
		end
		// New sample: output registers and FIFO
		if (st_r.ld_pend) begin
			st_nxt.x_r = smp[FIFO_W-1 -: SAMPLE_W];
			st_nxt.y_r = smp[2*SAMPLE_W-1 -: SAMPLE_W];
			st_nxt.z_r = smp[SAMPLE_W-1:0];
			if (st_nxt.fset[FMODE_HI:FMODE_LO] != FMODE_OFF) begin
				full = st_nxt.cnt == CNT_FULL;
				circ = mode == FMODE_CIRC ||
					(mode == FMODE_TRIG && !st_nxt.trig_seen);
				if (!full) begin
					st_nxt.mem[st_nxt.wr_ptr] = smp;
					st_nxt.wr_ptr = st_nxt.wr_ptr + 5'h01;
					st_nxt.cnt = st_nxt.cnt + 6'h01;
				end else begin
					// Set wins over a same-cycle status clear
					st_nxt.ovf = 1'b1;
					if (circ) begin
						// Oldest sample gives way to the newest
						st_nxt.mem[st_nxt.wr_ptr] = smp;
						st_nxt.wr_ptr = st_nxt.wr_ptr + 5'h01;
						st_nxt.rd_ptr = st_nxt.rd_ptr + 5'h01;
						st_nxt.pos = 3'h0;
					end
					// Otherwise the newest sample is dropped
				end
			end
		end
		st_nxt.wm = st_nxt.cnt > st_nxt.fset[WMRK_HI:0];
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from state
	assign reg_rdata = st_r.rdata;
	assign reg_next_addr = st_r.next_addr;
	assign fifo_watermark_flag = st_r.wm;
	assign fifo_overflow = st_r.ovf;
	assign range_select = st_r.dcfg[RANGE_HI:0];
	assign tap_hpf_bypass = st_r.hcut[TAP_HPF_BYP_BIT];
	assign tap_lpf_en = st_r.hcut[TAP_LPF_EN_BIT];

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// Quiet cycle: no competing register or sample activity
	logic quiet;
	assign quiet = !reg_wr && !st_r.ld_pend && !trig_event;

	a_low_byte_map: assert property (
		reg_rd && reg_addr == ADDR_XL && !fifo_on && !reg_wr
		|=> reg_rdata == lo_byte($past(st_r.x_r)))
		else $error("x low byte wrong");
	a_high_byte_map: assert property (
		reg_rd && reg_addr == ADDR_YH && !fifo_on && !reg_wr
		|=> reg_rdata == hi_byte($past(st_r.y_r)))
		else $error("y high byte wrong");
	a_fifo_zero_reads: assert property (
		reg_rd && fifo_on && reg_addr inside {[ADDR_XL:ADDR_ZL]}
		|=> reg_rdata == 8'h00)
		else $error("data window not zero");
	a_fast_skip: assert property (
		reg_rd && fast_read && reg_addr == ADDR_XH && !fifo_on
		|=> reg_next_addr == ADDR_YH)
		else $error("fast read did not skip");
	a_pop_count: assert property (
		reg_rd && reg_addr == ADDR_XH && fifo_on && quiet &&
		st_r.cnt != '0 && st_r.pos == last
		|=> st_r.cnt == $past(st_r.cnt) - 6'h01 && st_r.pos == 3'h0)
		else $error("pop did not decrement");
	a_burst_realign: assert property (
		burst_end && !reg_rd && st_r.pos != 3'h0 && quiet
		|=> st_r.pos == 3'h0 && st_r.rd_ptr == $past(st_r.rd_ptr) + 5'h01)
		else $error("partial sample kept");
	a_circ_wrap: assert property (
		st_r.ld_pend && mode == FMODE_CIRC && st_r.cnt == CNT_FULL &&
		!reg_rd && !reg_wr && !burst_end
		|=> st_r.cnt == CNT_FULL && st_r.rd_ptr == $past(st_r.rd_ptr) + 5'h01)
		else $error("circular overwrite failed");
	a_trig_drop: assert property (
		st_r.ld_pend && mode == FMODE_TRIG && st_r.trig_seen &&
		st_r.cnt == CNT_FULL && !reg_rd && !reg_wr && !burst_end
		|=> st_r.wr_ptr == $past(st_r.wr_ptr) && st_r.cnt == CNT_FULL)
		else $error("sample stored after trigger fill");
	a_ovf_sticky: assert property (
		st_r.ld_pend && fifo_on && st_r.cnt == CNT_FULL && !reg_wr &&
		!pop
		|=> fifo_overflow ##1 (fifo_overflow || $past(reg_rd)))
		else $error("overflow not held");
	a_wm_flag: assert property (
		st_r.ld_pend && fifo_on && !pop && !reg_wr &&
		st_r.cnt != CNT_FULL && st_r.cnt == st_r.fset[WMRK_HI:0]
		|=> fifo_watermark_flag && st_r.cnt == $past(st_r.cnt) + 6'h01)
		else $error("watermark flag wrong");
	a_tap_bits: assert property (
		reg_wr && reg_addr == ADDR_HCUT
		|=> tap_hpf_bypass == $past(reg_wdata[TAP_HPF_BYP_BIT]) &&
		tap_lpf_en == $past(reg_wdata[TAP_LPF_EN_BIT]))
		else $error("tap filter bits wrong");

	c_overflow: cover property (st_r.ld_pend && st_r.cnt == CNT_FULL);
	c_trigger: cover property (trig_event && mode == FMODE_TRIG);
	c_partial: cover property (burst_end && st_r.pos != 3'h0);
	c_watermark: cover property (!st_r.wm ##1 st_r.wm);
endmodule // accel_output_path

// file: rtl/accel_pkg.sv
package accel_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_XH = 8'h01;
	localparam logic [7:0] ADDR_XL = 8'h02;
	localparam logic [7:0] ADDR_YH = 8'h03;
	localparam logic [7:0] ADDR_YL = 8'h04;
	localparam logic [7:0] ADDR_ZH = 8'h05;
	localparam logic [7:0] ADDR_ZL = 8'h06;
	localparam logic [7:0] ADDR_FSETUP = 8'h09;
	localparam logic [7:0] ADDR_DCFG = 8'h0E;
	localparam logic [7:0] ADDR_HCUT = 8'h0F;
	// Reset value of every register
	localparam logic [7:0] REG_RESET = 8'h00;
	// Sample and FIFO geometry
	localparam int SAMPLE_W = 14;
	localparam int LOW_W = 6;
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_W = 3 * SAMPLE_W;
	localparam int PTR_W = 5;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
	// Read position of the last byte of a sample
	localparam logic [2:0] LAST_FULL = 3'h5;
	localparam logic [2:0] LAST_FAST = 3'h2;
	// Field positions
	localparam int FMODE_HI = 7;
	localparam int FMODE_LO = 6;
	localparam int WMRK_HI = 5;
	localparam int HPF_OUT_BIT = 4;
	localparam int RANGE_HI = 1;
	localparam int TAP_HPF_BYP_BIT = 5;
	localparam int TAP_LPF_EN_BIT = 4;
	localparam int CUT_HI = 1;
	// FIFO mode codes
	localparam logic [1:0] FMODE_OFF = 2'h0;
	localparam logic [1:0] FMODE_CIRC = 2'h1;
	localparam logic [1:0] FMODE_STOP = 2'h2;
	localparam logic [1:0] FMODE_TRIG = 2'h3;
	// Oversampling mode with the lowest filter corner
	localparam logic [1:0] PWR_LOW_POWER = 2'h3;
	// Clock and base output rate
	localparam int CLK_HZ = 25000000;
	localparam int BASE_ODR_HZ = 800;
	localparam int BASE_DIV = CLK_HZ / BASE_ODR_HZ;
	// High-pass filter fraction bits and base shift
	localparam int HPF_FRAC = 8;
	localparam int ACC_W = SAMPLE_W + HPF_FRAC;
	localparam logic [3:0] HPF_BASE_SHIFT = 4'h2;

	// Rate code to power-of-two slow-down from the base rate
	function automatic logic [3:0] rate_shift(input logic [2:0] code);
		case (code)
			3'h0: return 4'h0;
			3'h1: return 4'h1;
			3'h2: return 4'h2;
			3'h3: return 4'h3;
			3'h4: return 4'h4;
			3'h5: return 4'h6;
			3'h6: return 4'h7;
			default: return 4'h9;
		endcase
	endfunction

	// Upper byte of a left-justified sample
	function automatic logic [7:0] hi_byte(input logic [SAMPLE_W-1:0] s);
		return s[SAMPLE_W-1:LOW_W];
	endfunction

	// Lower byte of a left-justified sample, two unused bits
	function automatic logic [7:0] lo_byte(input logic [SAMPLE_W-1:0] s);
		return {s[LOW_W-1:0], 2'h0};
	endfunction
endpackage

// file: rtl/accel_hpf.sv
`timescale 1ns/1ps
module accel_hpf (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic en,
	input wire logic [3:0] shift,
	input wire logic [2:0][accel_pkg::SAMPLE_W-1:0] raw,
	output logic [2:0][accel_pkg::SAMPLE_W-1:0] filt
);
	import accel_pkg::*;

	// Running average and filtered output per axis
	typedef struct packed {
		logic [2:0][ACC_W-1:0] acc;
		logic [2:0][SAMPLE_W-1:0] out;
	} hpf_s;

	hpf_s st_r;
	hpf_s st_nxt;
	logic [2:0][ACC_W:0] diff;
	logic [2:0][ACC_W-1:0] acc_upd;

	// One first-order stage per axis
	genvar a;
	for (a = 0; a < 3; a++) begin : g_axis
		// Input minus the running average, both sign-extended by one bit
		assign diff[a] = {raw[a][SAMPLE_W-1], raw[a], {HPF_FRAC{1'b0}}}
			- {st_r.acc[a][ACC_W-1], st_r.acc[a]};
		// Average moves by a shifted share of the difference
		assign acc_upd[a] = st_r.acc[a]
			+ ACC_W'($signed(diff[a]) >>> shift);
	end

	// Update only on a new sample
	always_comb begin
		st_nxt = st_r;
		if (en) begin
			for (int i = 0; i < 3; i++) begin
				st_nxt.acc[i] = acc_upd[i];
				st_nxt.out[i] = diff[i][ACC_W-1:HPF_FRAC];
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign filt = st_r.out;
endmodule // accel_hpf

// file: verif/accel_host_model.sv
`timescale 1ns/1ps
// Serial engine side of the register port, one access at a time
module accel_host_model (
	input wire logic ref_clk,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	output logic burst_end
);
	// Idle port at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
		burst_end = 1'b0;
	end

	// Write strobe for one edge; released data is scrambled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		reg_addr <= ~a;
	endtask

	// Read strobe taken at one edge, answer settled after the next
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge ref_clk);
		#1 d = reg_rdata;
	endtask

	// End of a burst, never in the same cycle as a read strobe
	task automatic bend();
		@(posedge ref_clk);
		burst_end <= 1'b1;
		@(posedge ref_clk);
		burst_end <= 1'b0;
	endtask
endmodule // accel_host_model

// file: verif/accel_output_fifo_filter_cfg_tb_top.sv
`timescale 1ns/1ps
// Bench for the accelerometer output path
module accel_output_fifo_filter_cfg_tb_top;
	import accel_pkg::*;
	// Front-end patterns, X in the lowest slot
	localparam logic [2:0][13:0] SA = {14'h3F01, 14'h2345, 14'h1ABC};
	localparam logic [2:0][13:0] SB = {14'h0AAA, 14'h1555, 14'h0155};
	localparam logic [2:0][13:0] SC = {14'h2222, 14'h0F0F, 14'h3E00};
	logic ref_clk;
	logic rst_b;
	logic [2:0][13:0] v; // Sample inputs
	logic [2:0] wake_rate;
	logic [2:0] sleep_rate;
	logic sleep_act;
	logic fast;
	logic trig;
	logic hyb; // Hybrid rate select
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [7:0] reg_next_addr;
	logic reg_wr;
	logic reg_rd;
	logic burst_end;
	logic wm_flag;
	logic ovf;
	logic tap_byp;
	logic tap_lpf;
	logic [1:0] range_sel;
	logic [7:0] rd_d; // Last read answer
	int error_cnt;
	int n_checks;

	// Design with a short sample divider
	accel_output_path #(.BASE_DIV_CYC(4)) i_dut (
		.ref_clk(ref_clk), .rst_b(rst_b),
		.x_sample_bits(v[0]), .y_sample_bits(v[1]), .z_sample_bits(v[2]),
		.wake_rate_field(wake_rate), .sleep_rate_field(sleep_rate),
		.sleep_active(sleep_act), .hybrid_mode(hyb), .fast_read(fast),
		.power_mode(2'h0), .trig_event(trig), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.burst_end(burst_end), .reg_rdata(reg_rdata),
		.reg_next_addr(reg_next_addr), .fifo_watermark_flag(wm_flag),
		.fifo_overflow(ovf), .range_select(range_sel),
		.tap_hpf_bypass(tap_byp), .tap_lpf_en(tap_lpf)
	);

	// Host partner on the register port
	accel_host_model i_host (
		.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.burst_end(burst_end)
	);

	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// Expected register byte of a left-justified sample
	function automatic logic [7:0] eb(input logic [13:0] s, input int lo);
		return (lo != 0) ? {s[5:0], 2'h0} : s[13:6];
	endfunction

	// Count a comparison and report a mismatch
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Read one register and compare
	task automatic rc(input logic [7:0] a, input logic [7:0] e,
		input string nm);
		i_host.rd(a, rd_d);
		chk(nm, e, rd_d);
	endtask

	// Let edges pass, then step off the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Final counts and verdict
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Poll the status count under a bound
	task automatic wait_cnt(input logic [5:0] n);
		for (int i = 0; i < 4000; i++) begin
			i_host.rd(ADDR_STATUS, rd_d);
			if (rd_d[5:0] === n) return;
		end
		error_cnt++;
		$display("ERROR fifo count expected %h seen %h", n, rd_d[5:0]);
		summarize();
	endtask

	// Reset values, unmapped read and idle outputs
	task automatic t_reset();
		logic [7:0] a [0:9] = '{ADDR_XH, ADDR_XL, ADDR_YH, ADDR_YL, ADDR_ZH,
			ADDR_ZL, ADDR_FSETUP, ADDR_DCFG, ADDR_HCUT, 8'h0A};
		chk("outputs", 8'h00, {2'h0, wm_flag, ovf, tap_byp, tap_lpf, range_sel});
		for (int i = 0; i < 10; i++) begin
			rc(a[i], REG_RESET, "reset value");
		end
	endtask

	// Range codes and tap filter bits
	task automatic t_cfg();
		for (int i = 0; i < 4; i++) begin
			i_host.wr(ADDR_DCFG, 8'(i));
			cyc(2);
			chk("range_select", 8'(i), {6'h0, range_sel});
			rc(ADDR_DCFG, 8'(i), "data cfg");
		end
		i_host.wr(ADDR_HCUT, 8'h20);
		cyc(2);
		chk("tap bits", 8'h02, {6'h0, tap_byp, tap_lpf});
		i_host.wr(ADDR_HCUT, 8'h13);
		cyc(2);
		chk("tap bits", 8'h01, {6'h0, tap_byp, tap_lpf});
		rc(ADDR_HCUT, 8'h13, "cutoff cfg");
		i_host.wr(ADDR_DCFG, 8'h00);
		i_host.wr(ADDR_HCUT, 8'h00);
	endtask

	// Unfiltered direct output bytes and fast read
	task automatic t_direct();
		@(posedge ref_clk);
		v <= SA;
		cyc(30);
		for (int i = 0; i < 6; i++) begin
			rc(ADDR_XH + 8'(i), eb(SA[i/2], i%2), "direct");
		end
		@(posedge ref_clk);
		fast <= 1'b1;
		rc(ADDR_XH, eb(SA[0], 0), "fast XH");
		chk("fast next addr", ADDR_YH, reg_next_addr);
		rc(ADDR_XL, eb(SA[0], 1), "fast XL");
		@(posedge ref_clk);
		fast <= 1'b0;
	endtask

	// Filtered output decays for a constant input
	task automatic t_hpf();
		i_host.wr(ADDR_DCFG, 8'h10);
		cyc(400);
		// One positive and one negative axis
		for (int i = 0; i < 2; i++) begin
			i_host.rd(ADDR_XH + 8'(2 * i), rd_d);
			n_checks++;
			if (rd_d !== 8'h00 && rd_d !== 8'hFF) begin
				error_cnt++;
				$display("ERROR filtered high byte expected 00 or FF seen %h", rd_d);
			end
		end
		i_host.wr(ADDR_DCFG, 8'h00);
	endtask

	// Stop mode: order, watermark, overflow, partial bursts
	task automatic t_fifo();
		i_host.wr(ADDR_FSETUP, 8'h00);
		@(posedge ref_clk);
		sleep_rate <= 3'h7;
		sleep_act <= 1'b1;
		i_host.wr(ADDR_FSETUP, 8'h9F);
		rc(ADDR_YH, 8'h00, "fifo direct YH");
		wait_cnt(6'h01);
		@(posedge ref_clk);
		v <= SB;
		wait_cnt(6'h02);
		@(posedge ref_clk);
		v <= SC;
		sleep_act <= 1'b0;
		cyc(300);
		@(posedge ref_clk);
		sleep_act <= 1'b1;
		cyc(4);
		chk("overflow flag", 8'h01, {7'h0, ovf});
		rc(ADDR_STATUS, 8'hE0, "full status");
		chk("watermark flag", 8'h01, {7'h0, wm_flag});
		rc(ADDR_STATUS, 8'h60, "status reread");
		chk("overflow cleared", 8'h00, {7'h0, ovf});
		for (int i = 0; i < 6; i++) begin
			rc(ADDR_XH, eb(SA[i/2], i%2), "fifo head");
		end
		chk("fifo next addr", ADDR_XH, reg_next_addr);
		rc(ADDR_STATUS, 8'h1F, "after pop");
		rc(ADDR_XH, eb(SB[0], 0), "second XH");
		i_host.bend();
		rc(ADDR_XH, eb(SC[0], 0), "after partial");
		i_host.bend();
		rc(ADDR_STATUS, 8'h1D, "after partials");
		i_host.wr(ADDR_FSETUP, 8'h00);
	endtask

	// Circular modes keep the newest samples
	task automatic t_circ(input logic [7:0] setup);
		@(posedge ref_clk);
		sleep_act <= 1'b0;
		v <= SA;
		i_host.wr(ADDR_FSETUP, setup);
		cyc(300);
		@(posedge ref_clk);
		v <= SB;
		cyc(300);
		rc(ADDR_XH, eb(SB[0], 0), "circular head");
		i_host.bend();
	endtask

	// After the trigger the full buffer drops new samples
	task automatic t_trig();
		@(posedge ref_clk);
		trig <= 1'b1;
		v <= SC;
		@(posedge ref_clk);
		trig <= 1'b0;
		cyc(300);
		rc(ADDR_STATUS, 8'hE0, "trigger full");
		rc(ADDR_XH, eb(SB[0], 0), "head after trigger");
		i_host.bend();
	endtask

	// Hybrid mode halves the sample rate; fast FIFO samples are three bytes
	task automatic t_hyb();
		i_host.wr(ADDR_FSETUP, 8'h00);
		@(posedge ref_clk);
		hyb <= 1'b1;
		i_host.wr(ADDR_FSETUP, 8'h80);
		// 202 edges at one sample per 8 cycles
		cyc(200);
		i_host.rd(ADDR_STATUS, rd_d);
		n_checks++;
		if (rd_d[5:0] < 6'h19 || rd_d[5:0] > 6'h1A) begin
			error_cnt++;
			$display("ERROR hybrid count expected 19 to 1A seen %h", rd_d[5:0]);
		end
		@(posedge ref_clk);
		fast <= 1'b1;
		// Fourth read must start the next sample at X
		for (int i = 0; i < 4; i++) begin
			rc(ADDR_XH, eb(SC[i%3], 0), "fast fifo");
		end
		@(posedge ref_clk);
		fast <= 1'b0;
		hyb <= 1'b0;
		i_host.wr(ADDR_FSETUP, 8'h00);
	endtask

	// Main sequence
	initial begin
		rst_b = 1'b0;
		v = '0;
		wake_rate = 3'h0;
		sleep_rate = 3'h0;
		sleep_act = 1'b0;
		fast = 1'b0;
		trig = 1'b0;
		hyb = 1'b0;
		error_cnt = 0;
		n_checks = 0;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		cyc(1);
		t_reset();
		t_cfg();
		t_direct();
		t_hpf();
		t_fifo();
		t_circ(8'h40);
		i_host.wr(ADDR_FSETUP, 8'h00);
		t_circ(8'hC0);
		t_trig();
		t_hyb();
		summarize();
	end
endmodule // accel_output_fifo_filter_cfg_tb_top
